// file: fsw_pkg.sv
// Shared constants and types for the flash word and stream program sequencer.
// Assumes a 25 MHz system clock and a 16-bit word array split into partitions and blocks.
package fsw_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NPART = 4;
  localparam int NBLK = 16;
  localparam int PART_LSB = 6;
  localparam int BLK_LSB = 4;
  localparam int MEM_WORDS = 256;
  localparam int SYNC_W = 46;
  localparam int TMR_W = 16;

  typedef logic [ADDR_W-1:0] fsw_addr_t;
  typedef logic [DATA_W-1:0] fsw_data_t;
  typedef logic [NBLK-1:0] fsw_lock_t;
  typedef logic [1:0] fsw_part_t;
  typedef logic [3:0] fsw_blk_t;
  typedef logic [TMR_W-1:0] fsw_cyc_t;

  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_STREAM = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_RD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_RD_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_RD_ID = 8'h90;
  localparam logic [7:0] CMD_RD_QUERY = 8'h98;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;

  localparam int SR_READY = 7;
  localparam int SR_PS = 4;
  localparam int SR_VPP = 3;
  localparam int SR_PSUS = 2;
  localparam int SR_DPS = 1;
  localparam int SR_PWB = 0;
  localparam int E_PS = 2;
  localparam int E_VPP = 1;
  localparam int E_DPS = 0;

  localparam fsw_data_t ERASED_WORD = 16'hFFFF;
  localparam fsw_data_t ID_WORD = 16'h5A3C;  // Arbitrary value
  localparam fsw_data_t QUERY_WORD = 16'h00A5;  // Arbitrary value
  localparam logic [2:0] VERIFY_MAX = 3'h4;

  localparam int CLK_NS = 40;
  localparam int PULSE_NS = 400;
  localparam int SETUP_NS = 2000;
  localparam int EXIT_NS = 400;
  localparam fsw_cyc_t PULSE_CYC = fsw_cyc_t'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam fsw_cyc_t SETUP_CYC = fsw_cyc_t'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam fsw_cyc_t EXIT_CYC = fsw_cyc_t'((EXIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [SYNC_W-1:0] SYNC_RST = {3'h7, 43'h0};

  typedef enum logic [3:0] {
    S_IDLE, S_PROG, S_SUSP, S_SETUP, S_PRG_RDY, S_PRG_PULSE,
    S_VER_RDY, S_VER_CHK, S_VER_PULSE, S_EXIT
  } fsw_state_e;
  typedef enum logic [1:0] {M_ARRAY, M_STATUS, M_ID, M_QUERY} fsw_mode_e;
  typedef enum logic [1:0] {PEND_NONE, PEND_PROG, PEND_STREAM} fsw_pend_e;
endpackage

// file: fsw_tmr_if.sv
// Start and done handshake between the sequencer and its pulse timer.
// Assumes both ends run on clk_sys.
interface fsw_tmr_if;
  logic start;
  fsw_pkg::fsw_cyc_t cycles;
  logic done;
  modport ctl (output start, output cycles, input done);
  modport tmr (input start, input cycles, output done);
endinterface

// file: fsw_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes every bit is a slow level; no bus coherence is promised.
module fsw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      meta_q <= RST;
      q <= RST;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: fsw_timer.sv
// Down counter for internal pulse, setup and exit durations.
// Assumes start is a one-cycle pulse with a nonzero cycle count.
module fsw_timer (
  input wire logic clk_sys,
  input wire logic reset_n,
  fsw_tmr_if.tmr t
);
  import fsw_pkg::*;
  fsw_cyc_t cnt_q;
  logic done_q;
  assign t.done = done_q;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end
    else if (t.start)
    begin
      cnt_q <= t.cycles;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (cnt_q == 16'h0001);
      if (cnt_q != 16'h0000)
        cnt_q <= cnt_q - 16'h0001;
    end
  end
endmodule

// file: fsw_sequencer.sv
// Word program and stream program sequencer with per-partition status.
// Assumes asynchronous bus pins and supply/lock levels; all are synchronised here.
import fsw_pkg::*;

// Operation
// - Programming only clears bits; a one in the data leaves the cell alone.
// - Word program is setup 40h or 10h, then one data write.
// - One partition programs at a time; others read or sit suspended.
// - Bit 7 is whole-device busy/ready for any partition read.
// - Status output is relatched on each chip select or output enable toggle.
// - A programming partition accepts status, suspend, identifier, query; array reads indeterminate.
// - Program end sets bit 4 fail, bit 3 supply bad, bit 1 locked.
// - After programming, partition reads status until another command arrives.
// - Bits 4, 3, 1 clear only by clear command; bit 3 blocks programming (here only word program; stream setup ignores bit 3).
// - Standby waits until an active program operation completes.
// - Stream entry is 30h then D0h; ready bit drops, host waits setup.
// - Stream setup checks supply and lock; errors set bits and abandon.
// - After confirm every read is status; writes are data.
// - After setup with bit 0 low, each write is a data word.
// - Each data write gets one pulse; bit 0 high during the pulse.
// - After each stream pulse the internal address steps to the next word.
// - Address equal to first word address uses next location, else jumps.
// - Write outside the target block ends program phase, enters verify.
// - Verify compares each word, adds pulses and stays busy on mismatch.
// - Stream mode: one block, no suspend, no other-partition reads.
// - All-ones write to another block ends verify and enters exit; here any write outside the block does, whatever the data.
// - Leaving stream mode raises the ready bit again.
// - A word still failing after verify pulses sets bit 4.
module fsw_sequencer (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire fsw_pkg::fsw_addr_t addr,
  input wire fsw_pkg::fsw_data_t dq_in,
  output fsw_pkg::fsw_data_t dq_out,
  output logic dq_oe,
  input wire logic vpp_ok,
  input wire logic vpp_high,
  input wire fsw_pkg::fsw_lock_t block_lock,
  input wire logic cell_weak,
  output logic device_ready,
  output logic standby
);
  import fsw_pkg::*;

  function automatic fsw_part_t part_of(input fsw_addr_t a);
    return a[ADDR_W-1:PART_LSB];
  endfunction

  function automatic fsw_blk_t blk_of(input fsw_addr_t a);
    return a[ADDR_W-1:BLK_LSB];
  endfunction

  logic [SYNC_W-1:0] pins_s;
  logic ce_n_s;
  logic oe_n_s;
  logic we_n_s;
  fsw_addr_t addr_s;
  fsw_data_t din_s;
  logic vpp_ok_s;
  logic vpp_high_s;
  logic weak_s;
  fsw_lock_t lock_s;

  fsw_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .d({ce_n, oe_n, we_n, addr, dq_in, vpp_ok, vpp_high, cell_weak, block_lock}),
    .q(pins_s)
  );
  assign {ce_n_s, oe_n_s, we_n_s, addr_s, din_s, vpp_ok_s, vpp_high_s, weak_s, lock_s} = pins_s;

  fsw_state_e state_q;
  fsw_pend_e pend_q;
  fsw_mode_e mode_q [NPART];
  logic [2:0] err_q [NPART];
  fsw_data_t mem [MEM_WORDS];
  fsw_addr_t wa0_q;
  fsw_addr_t ptr_q;
  fsw_addr_t tgt_q;
  fsw_data_t wdat_q;
  logic [2:0] retry_q;
  fsw_part_t busy_part_q;
  logic tmr_start_q;
  fsw_cyc_t tmr_cyc_q;
  logic we_n_p;
  logic rd_en_p;
  fsw_data_t dq_out_q;
  logic dq_oe_q;
  logic ready_q;
  logic standby_q;

  fsw_tmr_if tmr ();
  assign tmr.start = tmr_start_q;
  assign tmr.cycles = tmr_cyc_q;
  fsw_timer u_tmr (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .t(tmr.tmr)
  );

  logic rd_en;
  logic rd_fall;
  logic wr_ev;
  logic [7:0] cmd;
  fsw_part_t wpart;
  fsw_part_t rpart;
  logic dev_ready;
  logic stream_on;
  logic in_blk;
  fsw_addr_t tgt_sel;
  logic prog_req;
  logic prog_go;
  logic setup_fail;
  logic ver_match;
  logic pulse_end;
  logic clr_ev;
  logic [2:0] err_set;
  fsw_part_t err_part;
  logic [7:0] sr;
  fsw_data_t rd_word;

  // Edges are taken from the second synchroniser stage only
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      we_n_p <= 1'b1;
      rd_en_p <= 1'b0;
    end
    else
    begin
      we_n_p <= we_n_s;
      rd_en_p <= rd_en;
    end
  end

  assign rd_en = ~ce_n_s & ~oe_n_s;
  assign rd_fall = rd_en & ~rd_en_p;
  // Write taken on the rising edge of the write strobe
  assign wr_ev = we_n_s & ~we_n_p & ~ce_n_s;
  assign cmd = din_s[7:0];
  assign wpart = part_of(addr_s);
  assign rpart = part_of(addr_s);
  assign dev_ready = (state_q == S_IDLE) || (state_q == S_SUSP);
  // Word programming leaves partition commands and other-partition reads open
  assign stream_on = !dev_ready && (state_q != S_PROG);
  assign in_blk = blk_of(addr_s) == blk_of(wa0_q);
  assign tgt_sel = (addr_s == wa0_q) ? ptr_q : addr_s;
  assign prog_req = wr_ev && (state_q == S_IDLE) && (pend_q == PEND_PROG);
  assign prog_go = prog_req && !err_q[wpart][E_VPP] && vpp_ok_s && !lock_s[blk_of(addr_s)];
  assign setup_fail = !vpp_high_s || lock_s[blk_of(wa0_q)];
  assign ver_match = mem[tgt_q] == wdat_q;
  assign pulse_end = tmr.done && (state_q inside {S_PROG, S_PRG_PULSE, S_VER_PULSE});
  assign clr_ev = wr_ev && dev_ready && (pend_q == PEND_NONE) && (cmd == CMD_CLR_STATUS);

  // Only one error source can fire per cycle since they belong to exclusive states
  always_comb
  begin
    err_set = 3'h0;
    err_part = busy_part_q;
    if (prog_req && !err_q[wpart][E_VPP])
    begin
      err_part = wpart;
      if (!vpp_ok_s)
        err_set[E_VPP] = 1'b1;
      else if (lock_s[blk_of(addr_s)])
        err_set[E_DPS] = 1'b1;
    end
    else if ((state_q == S_PROG) && tmr.done && weak_s)
      err_set[E_PS] = 1'b1;
    else if ((state_q == S_SETUP) && tmr.done)
    begin
      err_set[E_VPP] = !vpp_high_s;
      err_set[E_DPS] = lock_s[blk_of(wa0_q)];
    end
    else if ((state_q == S_VER_CHK) && !ver_match && (retry_q == VERIFY_MAX))
      err_set[E_PS] = 1'b1;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NPART; i++)
        err_q[i] <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < NPART; i++)
      begin
        if (clr_ev && (wpart == fsw_part_t'(i)))
          err_q[i] <= (err_part == fsw_part_t'(i)) ? err_set : 3'h0;
        else if (err_part == fsw_part_t'(i))
          err_q[i] <= err_q[i] | err_set;
      end
    end
  end

  // Array cells; a weak cell ignores the pulse so verify has work to do
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < MEM_WORDS; i++)
        mem[i] <= ERASED_WORD;
    end
    else if (pulse_end && !weak_s)
      mem[tgt_q] <= mem[tgt_q] & wdat_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_q <= S_IDLE;
      pend_q <= PEND_NONE;
      wa0_q <= '0;
      ptr_q <= '0;
      tgt_q <= '0;
      wdat_q <= '0;
      retry_q <= 3'h0;
      busy_part_q <= '0;
      tmr_start_q <= 1'b0;
      tmr_cyc_q <= '0;
    end
    else
    begin
      tmr_start_q <= 1'b0;
      unique case (state_q)
        S_IDLE:
        begin
          if (wr_ev)
          begin
            unique case (pend_q)
              PEND_PROG:
              begin
                pend_q <= PEND_NONE;
                if (prog_go)
                begin
                  tgt_q <= addr_s;
                  wdat_q <= din_s;
                  busy_part_q <= wpart;
                  tmr_start_q <= 1'b1;
                  tmr_cyc_q <= PULSE_CYC;
                  state_q <= S_PROG;
                end
              end
              PEND_STREAM:
              begin
                pend_q <= PEND_NONE;
                if (cmd == CMD_CONFIRM)
                begin
                  busy_part_q <= part_of(wa0_q);
                  tmr_start_q <= 1'b1;
                  tmr_cyc_q <= SETUP_CYC;
                  state_q <= S_SETUP;
                end
              end
              PEND_NONE:
              begin
                if ((cmd == CMD_PROG) || (cmd == CMD_PROG_ALT))
                  pend_q <= PEND_PROG;
                else if (cmd == CMD_STREAM)
                begin
                  pend_q <= PEND_STREAM;
                  wa0_q <= addr_s;
                end
              end
            endcase
          end
        end
        S_PROG:
        begin
          if (tmr.done)
            state_q <= S_IDLE;
          else if (wr_ev && (cmd == CMD_SUSPEND))
            state_q <= S_SUSP;
        end
        S_SUSP:
        begin
          // Resume restarts the whole pulse; a partial pulse is not remembered
          if (wr_ev && (cmd == CMD_CONFIRM))
          begin
            tmr_start_q <= 1'b1;
            tmr_cyc_q <= PULSE_CYC;
            state_q <= S_PROG;
          end
        end
        S_SETUP:
        begin
          if (tmr.done)
          begin
            ptr_q <= wa0_q;
            state_q <= setup_fail ? S_IDLE : S_PRG_RDY;
          end
        end
        S_PRG_RDY:
        begin
          if (wr_ev && !in_blk)
          begin
            ptr_q <= wa0_q;
            state_q <= S_VER_RDY;
          end
          else if (wr_ev)
          begin
            tgt_q <= tgt_sel;
            wdat_q <= din_s;
            tmr_start_q <= 1'b1;
            tmr_cyc_q <= PULSE_CYC;
            state_q <= S_PRG_PULSE;
          end
        end
        S_PRG_PULSE:
        begin
          if (tmr.done)
          begin
            ptr_q <= fsw_addr_t'(tgt_q + 8'h01);
            state_q <= S_PRG_RDY;
          end
        end
        S_VER_RDY:
        begin
          if (wr_ev && !in_blk)
          begin
            tmr_start_q <= 1'b1;
            tmr_cyc_q <= EXIT_CYC;
            state_q <= S_EXIT;
          end
          else if (wr_ev)
          begin
            tgt_q <= tgt_sel;
            wdat_q <= din_s;
            retry_q <= 3'h0;
            state_q <= S_VER_CHK;
          end
        end
        S_VER_CHK:
        begin
          if (ver_match || (retry_q == VERIFY_MAX))
          begin
            ptr_q <= fsw_addr_t'(tgt_q + 8'h01);
            state_q <= S_VER_RDY;
          end
          else
          begin
            retry_q <= retry_q + 3'h1;
            tmr_start_q <= 1'b1;
            tmr_cyc_q <= PULSE_CYC;
            state_q <= S_VER_PULSE;
          end
        end
        S_VER_PULSE:
        begin
          if (tmr.done)
            state_q <= S_VER_CHK;
        end
        S_EXIT:
        begin
          if (tmr.done)
            state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Read mode per partition; stream mode freezes all modes
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NPART; i++)
        mode_q[i] <= M_ARRAY;
    end
    else if (wr_ev && !stream_on && (state_q != S_PROG || pend_q == PEND_NONE))
    begin
      if (pend_q != PEND_NONE)
        mode_q[wpart] <= M_STATUS;
      else
      begin
        case (cmd)
          CMD_RD_ARRAY: mode_q[wpart] <= M_ARRAY;
          CMD_RD_ID: mode_q[wpart] <= M_ID;
          CMD_RD_QUERY: mode_q[wpart] <= M_QUERY;
          CMD_RD_STATUS, CMD_PROG, CMD_PROG_ALT, CMD_STREAM, CMD_SUSPEND, CMD_CONFIRM:
            mode_q[wpart] <= M_STATUS;
          default: mode_q[wpart] <= mode_q[wpart];
        endcase
      end
    end
  end

  always_comb
  begin
    sr = 8'h00;
    sr[SR_READY] = dev_ready;
    sr[SR_PS] = err_q[rpart][E_PS];
    sr[SR_VPP] = err_q[rpart][E_VPP];
    sr[SR_DPS] = err_q[rpart][E_DPS];
    sr[SR_PSUS] = (state_q == S_SUSP) && (rpart == busy_part_q);
    if (state_q inside {S_SETUP, S_PRG_PULSE, S_VER_CHK, S_VER_PULSE})
      sr[SR_PWB] = 1'b1;
    else if (state_q == S_PROG)
      sr[SR_PWB] = rpart != busy_part_q;
  end

  always_comb
  begin
    rd_word = {8'h00, sr};
    if (!stream_on && (state_q != S_PROG || rpart != busy_part_q || mode_q[rpart] != M_STATUS))
    begin
      unique case (mode_q[rpart])
        // Busy partition array data is indeterminate; raw cells are returned
        M_ARRAY: rd_word = mem[addr_s];
        M_STATUS: rd_word = {8'h00, sr};
        M_ID: rd_word = ID_WORD;
        M_QUERY: rd_word = QUERY_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      dq_out_q <= '0;
      dq_oe_q <= 1'b0;
      ready_q <= 1'b1;
      standby_q <= 1'b0;
    end
    else
    begin
      if (rd_fall)
        dq_out_q <= rd_word;
      dq_oe_q <= rd_en;
      ready_q <= dev_ready;
      standby_q <= ce_n_s && (state_q != S_PROG) && !stream_on;
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;
  assign device_ready = ready_q;
  assign standby = standby_q;
endmodule

// file: fsw_monitor.sv
// Port checker for the flash word and stream program sequencer.
// Assumes bus pins only move on the falling clock edge.
module fsw_monitor (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire fsw_pkg::fsw_addr_t addr,
  input wire fsw_pkg::fsw_data_t dq_in,
  input wire fsw_pkg::fsw_data_t dq_out,
  input wire logic dq_oe,
  input wire logic vpp_ok,
  input wire logic vpp_high,
  input wire fsw_pkg::fsw_lock_t block_lock,
  input wire logic cell_weak,
  input wire logic device_ready,
  input wire logic standby
);
  import fsw_pkg::*;
  logic [3:0] we_age_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Cycles since the write strobe pin last rose, saturating
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      we_age_q <= 4'hF;
    else if ($rose(we_n))
      we_age_q <= 4'h0;
    else if (we_age_q != 4'hF)
      we_age_q <= we_age_q + 4'h1;
  end

  sequence s_read_start;
    $fell(ce_n | oe_n);
  endsequence
  sequence s_busy_begin;
    $fell(device_ready);
  endsequence

  property p_oe_on;
    s_read_start |-> ##[2:4] dq_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("read data not driven after read start");
  property p_oe_off;
    (ce_n | oe_n) [*5] |-> !dq_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("read data driven without a read");
  property p_dq_hold;
    $changed(dq_out) |-> dq_oe && !$past(dq_oe);
  endproperty
  a_dq_hold: assert property (p_dq_hold)
    else $error("read data changed outside a read start");
  property p_selected_awake;
    (!ce_n) [*5] |-> !standby;
  endproperty
  a_selected_awake: assert property (p_selected_awake)
    else $error("standby while selected");
  property p_busy_awake;
    !device_ready |-> !standby;
  endproperty
  a_busy_awake: assert property (p_busy_awake)
    else $error("standby while an operation runs");
  property p_standby_cause;
    standby |-> $past(ce_n, 2) || $past(ce_n, 3) || $past(ce_n, 4);
  endproperty
  a_standby_cause: assert property (p_standby_cause)
    else $error("standby without deselect");
  property p_ready_cause;
    s_busy_begin |-> we_age_q <= 4'h6;
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("device went busy without a write");
  property p_ready_low_min;
    s_busy_begin |-> !device_ready [*8];
  endproperty
  a_ready_low_min: assert property (p_ready_low_min)
    else $error("busy period shorter than a pulse");
endmodule

bind fsw_sequencer fsw_monitor u_fsw_monitor (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .ce_n(ce_n),
  .oe_n(oe_n),
  .we_n(we_n),
  .addr(addr),
  .dq_in(dq_in),
  .dq_out(dq_out),
  .dq_oe(dq_oe),
  .vpp_ok(vpp_ok),
  .vpp_high(vpp_high),
  .block_lock(block_lock),
  .cell_weak(cell_weak),
  .device_ready(device_ready),
  .standby(standby)
);

// file: fsw_host_model.sv
// Host model driving the asynchronous flash bus pins.
// Assumes the bench clock; pins change on its falling edge only.
module fsw_host_model (
  input wire logic clk_sys,
  input wire fsw_pkg::fsw_data_t dq_out,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output fsw_pkg::fsw_addr_t addr,
  output fsw_pkg::fsw_data_t dq_in
);
  import fsw_pkg::*;

  initial
  begin
    ce_n = 1'h1;
    oe_n = 1'h1;
    we_n = 1'h1;
    addr = 8'h00;
    dq_in = 16'h0000;
  end

  // Strobe held low and high three clocks each to cover synchroniser lag
  task automatic wr(input fsw_addr_t a, input fsw_data_t v);
    @(negedge clk_sys);
    ce_n = 1'h0;
    addr = a;
    dq_in = v;
    we_n = 1'h0;
    repeat (3) @(negedge clk_sys);
    we_n = 1'h1;
    repeat (3) @(negedge clk_sys);
    ce_n = 1'h0 ^ 1'h1;
    // Released data bus shows the inverse, never the old word
    dq_in = ~v;
  endtask

  task automatic rd(input fsw_addr_t a, output fsw_data_t v);
    @(negedge clk_sys);
    ce_n = 1'h0;
    addr = a;
    oe_n = 1'h0;
    repeat (4) @(negedge clk_sys);
    v = dq_out;
    oe_n = 1'h1;
    ce_n = 1'h1;
    repeat (3) @(negedge clk_sys);
  endtask
endmodule

// file: tb_flash_word_and_stream_program.sv
// Self-checking bench for the flash word and stream program sequencer.
// Assumes the host model owns the bus pins; supply, lock and weak-cell inputs are driven here.
module tb_flash_word_and_stream_program;
  timeunit 1ns;
  timeprecision 1ns;
  import fsw_pkg::*;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic ce_n, oe_n, we_n, dq_oe, device_ready, standby, vpp_ok, vpp_high, cell_weak;
  fsw_addr_t addr;
  fsw_data_t dq_in, dq_out, s;
  fsw_lock_t block_lock;
  logic [15:0] seed = 16'h0012;
  int n_mismatch = 0;
  int tests_run = 0;
  int mem [MEM_WORDS];
  int ptr;
  fsw_addr_t tgt [4];
  fsw_data_t dat [4];
  logic [2:0] ctl_tab [6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h0, 3'h4};
  fsw_data_t sr_tab [6] = '{16'h0080, 16'h0080, 16'h0082, 16'h0088, 16'h0088, 16'h0090};

  always #20 clk_sys = ~clk_sys;

  fsw_host_model host (.clk_sys(clk_sys), .dq_out(dq_out), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .dq_in(dq_in));
  fsw_sequencer DUT (.clk_sys(clk_sys), .reset_n(reset_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .vpp_ok(vpp_ok),
    .vpp_high(vpp_high), .block_lock(block_lock), .cell_weak(cell_weak),
    .device_ready(device_ready), .standby(standby));

  function automatic fsw_data_t rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input fsw_data_t exp, input fsw_data_t got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Status reads toggle select each time, so every read is fresh
  task automatic poll(input fsw_addr_t a, input int b, input logic v);
    for (int i = 0; i < 200; i++)
    begin
      host.rd(a, s);
      if (s[b] === v)
        return;
    end
    n_mismatch++;
    $display("[FAIL] poll bit %0d expected %b seen %b", b, v, s[b]);
    end_sim();
  endtask

  task automatic word_prog(input logic [7:0] cmd, input fsw_data_t v, input fsw_data_t sr);
    host.wr(8'h05, {8'h00, cmd});
    host.wr(8'h05, v);
    host.rd(8'h45, s);
    check("device ready bit", 16'(sr[3] | sr[1]), 16'(s[SR_READY]));
    poll(8'h05, SR_READY, 1'h1);
    check("word status", sr, s);
  endtask

  initial
  begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    vpp_ok = 1'h1;
    vpp_high = 1'h0;
    cell_weak = 1'h0;
    block_lock = '0;
    foreach (mem[i]) mem[i] = 32'h0000FFFF;
    repeat (6) @(negedge clk_sys);
    check("reset outputs", 16'h0002, 16'({dq_oe, standby, device_ready, dq_out != 16'h0000}));
    reset_n = 1'h1;
    repeat (8) @(negedge clk_sys);
    check("idle standby", 16'h0001, 16'(standby));
    host.wr(8'h45, {8'h00, CMD_RD_STATUS});
    for (int i = 0; i < 6; i++)
    begin
      block_lock = {15'h0000, ctl_tab[i][0]};
      vpp_ok = !ctl_tab[i][1];
      cell_weak = ctl_tab[i][2];
      dat[0] = rnd();
      word_prog((i % 2) ? CMD_PROG_ALT : CMD_PROG, dat[0], sr_tab[i]);
      if (sr_tab[i] === 16'h0080)
        mem[5] = mem[5] & int'(dat[0]);
      if (i != 3)
        host.wr(8'h05, {8'h00, CMD_CLR_STATUS});
    end
    cell_weak = 1'h0;
    host.rd(8'h05, s);
    check("status mode", 16'h0080, s);
    host.wr(8'h05, {8'h00, CMD_RD_ARRAY});
    host.rd(8'h05, s);
    check("array word", 16'(mem[5]), s);
    host.wr(8'h06, {8'h00, CMD_PROG});
    host.wr(8'h06, 16'h00FF);
    mem[6] = mem[6] & 32'h000000FF;
    host.wr(8'h06, {8'h00, CMD_RD_ID});
    host.rd(8'h06, s);
    check("busy identifier", ID_WORD, s);
    host.wr(8'h06, {8'h00, CMD_RD_STATUS});
    poll(8'h06, SR_READY, 1'h1);
    check("identifier status", 16'h0080, s);
    host.wr(8'h06, {8'h00, CMD_RD_ARRAY});
    host.rd(8'h06, s);
    check("second word", 16'(mem[6]), s);
    for (int i = 0; i < 2; i++)
    begin
      vpp_high = i[0];
      block_lock = 16'(i) << 2;
      host.wr(8'h20, {8'h00, CMD_STREAM});
      host.wr(8'h20, {8'h00, CMD_CONFIRM});
      poll(8'h20, SR_READY, 1'h1);
      check("stream setup fault", i ? 16'h0082 : 16'h0088, s);
      host.wr(8'h20, {8'h00, CMD_CLR_STATUS});
    end
    block_lock = '0;
    host.wr(8'h20, {8'h00, CMD_STREAM});
    host.wr(8'h20, {8'h00, CMD_CONFIRM});
    repeat (5) @(negedge clk_sys);
    check("setup busy", 16'h0000, 16'({standby, device_ready}));
    poll(8'h20, SR_PWB, 1'h0);
    check("stream ready", 16'h0000, s);
    host.rd(8'h85, s);
    check("other partition", 16'h0000, s & 16'hFF80);
    ptr = 8'h20;
    for (int i = 0; i < 4; i++)
    begin
      dat[i] = rnd() & 16'h7FFF;
      cell_weak = (i == 1);
      host.wr((i == 2) ? 8'h26 : 8'h20, dat[i]);
      tgt[i] = (i == 2) ? 8'h26 : fsw_addr_t'(ptr);
      ptr = tgt[i] + 1;
      if (i != 1)
        mem[tgt[i]] = mem[tgt[i]] & int'(dat[i]);
      host.rd(8'h20, s);
      check("pulse busy", 16'h0001, s);
      poll(8'h20, SR_PWB, 1'h0);
      check("word done", 16'h0000, s);
    end
    host.wr(8'h30, ERASED_WORD);
    poll(8'h20, SR_PWB, 1'h0);
    for (int i = 0; i < 4; i++)
    begin
      cell_weak = (i == 1);
      host.wr((i == 2) ? 8'h26 : 8'h20, dat[i]);
      poll(8'h20, SR_PWB, 1'h0);
      // Second word never verifies, so the program-fail bit stays up from then on
      check("verify done", (i > 0) ? 16'h0010 : 16'h0000, s);
    end
    cell_weak = 1'h0;
    host.wr(8'h30, ERASED_WORD);
    poll(8'h20, SR_READY, 1'h1);
    check("exit status", 16'h0090, s);
    host.wr(8'h20, {8'h00, CMD_CLR_STATUS});
    host.wr(8'h20, {8'h00, CMD_RD_ARRAY});
    for (int i = 0; i < 4; i++)
    begin
      host.rd(tgt[i], s);
      check("stream word", 16'(mem[tgt[i]]), s);
    end
    end_sim();
  end
endmodule
